// ==== verilog/asu_sync_action.sv ====
`timescale 1ns/1ps
module asu_sync_action #(
	parameter int AXES = 4
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire asu_pkg::asu_axis_in_t [AXES-1:0] axis_in,
	input wire logic [AXES-1:0] gin3_pin,
	output asu_pkg::asu_axis_act_t [AXES-1:0] axis_act,
	output logic [AXES-1:0][31:0] preset_value,
	output logic [AXES-1:0] soft_limit_en
);
	import asu_pkg::*;

	// The rotation of target codes is defined for exactly four axes
	initial begin
		if (AXES != asu_pkg::AXES) begin
			$error("asu_sync_action: only four axes are supported");
		end
	end

	// Reset release through two flops
	logic rst_meta_q;
	logic rst_n;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// General input pins are asynchronous: two flops each
	logic [AXES-1:0] gin3_meta_q;
	logic [AXES-1:0] gin3_q;
	generate
		for (genvar a = 0; a < AXES; a++) begin : g_gin_sync
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					gin3_meta_q[a] <= 1'b0;
					gin3_q[a] <= 1'b0;
				end else begin
					gin3_meta_q[a] <= gin3_pin[a];
					gin3_q[a] <= gin3_meta_q[a];
				end
			end
		end
	endgenerate

	// Re-learn levels once the pin syncs have filled, so a high pin is no edge
	logic boot_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_q <= 1'b1;
		end else begin
			boot_q <= 1'b0;
		end
	end

	// Bus handshake state
	asu_bus_st_t st_q;
	asu_bus_st_t st_d;
	logic req;
	logic wr_commit;
	logic in_bank;
	logic [3:0] bank_idx;
	logic [31:0] bank_rd;
	logic [BANK_WORDS-1:0][31:0] bank_words;
	logic [31:0] dat_d;
	logic [31:0] wmerge;

	// Configuration and status state
	asu_cfg_t cfg_q;
	asu_cfg_t cfg_d;
	logic [31:0] src_q;
	logic [31:0] src_d;
	logic [31:0] capture_q;
	logic [31:0] capture_d;
	logic [7:0] last_q;
	logic [7:0] last_d;
	asu_axis_act_t [AXES-1:0] act_d;

	// Trigger path
	logic [1:0] mon;
	logic [3:0] mon_oh;
	logic [3:0] tgt_mask;
	logic [31:0] cmp_hi;
	logic [31:0] cmp_lo;
	logic [31:0] watched_pos;
	logic [7:0] factors;
	logic [7:0] fired;
	logic fire;
	logic restart;

	assign req = wb_cyc_i && wb_stb_i;
	assign wr_commit = (st_q == BUS_PEND) && wb_we_i;
	assign in_bank = (wb_adr_i >= OFS_CMP_HI) && (wb_adr_i < OFS_END);
	assign bank_idx = wb_adr_i[5:2] - IDX_PRESET + IDX_CMP_LO;

	// Request seen, one cycle for the bank read, then ack
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			BUS_IDLE: begin
				if (req) begin
					st_d = BUS_PEND;
				end
			end
			BUS_PEND: begin
				st_d = BUS_ACK;
			end
			BUS_ACK: begin
				st_d = BUS_IDLE;
			end
			default: begin
				st_d = BUS_IDLE;
			end
		endcase
	end

	// Merge write data into a word by byte lanes
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] sel, input logic [31:0] wmask);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return r & wmask;
	endfunction

	// Read mux, captured into the data register just before ack
	always_comb begin
		dat_d = wb_dat_o;
		if (st_q == BUS_PEND && !wb_we_i) begin
			if (in_bank) begin
				dat_d = bank_rd;
			end else begin
				unique case (wb_adr_i)
					OFS_CFG: dat_d = cfg_q;
					OFS_SRC: dat_d = src_q;
					OFS_STAT: begin
						dat_d = 32'h00000000;
						for (int a = 0; a < AXES; a++) begin
							dat_d[STAT_DRV_LSB + a] = axis_in[a].driving;
						end
						dat_d[STAT_LAST_LSB +: 8] = last_q;
					end
					OFS_CAPT: dat_d = capture_q;
					default: dat_d = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= BUS_IDLE;
			wb_dat_o <= 32'h00000000;
		end else begin
			st_q <= st_d;
			wb_dat_o <= dat_d;
		end
	end

	assign wb_ack_o = (st_q == BUS_ACK);

	// Compare, preset words; index 0-3 upper, 4-7 lower, 8-11 preset
	asu_word_bank #(
		.W(32),
		.WORDS(BANK_WORDS),
		.AW(4)
	) u_bank (
		.clk(core_clk),
		.rst_n(rst_n),
		.wr_en(wr_commit && in_bank),
		.wr_idx(bank_idx),
		.wr_sel(wb_sel_i),
		.wr_data(wb_dat_i),
		.rd_idx(bank_idx),
		.rd_data(bank_rd),
		.hi_idx(IDX_CMP_HI + {2'b00, mon}),
		.lo_idx(IDX_CMP_LO + {2'b00, mon}),
		.hi_data(cmp_hi),
		.lo_data(cmp_lo),
		.words(bank_words)
	);

	// Presets drive the axes directly so a load can use them on the trigger
	generate
		for (genvar a = 0; a < AXES; a++) begin : g_preset
			assign preset_value[a] = bank_words[32'(IDX_PRESET) + a];
		end
	endgenerate

	// Monitored axis and the target set relative to it
	function automatic logic [3:0] target_decode(input logic [1:0] m, input logic [2:0] code);
		logic [3:0] r;
		logic [1:0] idx;
		r = 4'h0;
		for (int k = 0; k < 3; k++) begin
			idx = m + 2'(k + 1);
			r[idx] = code[k];
		end
		return r;
	endfunction

	assign mon = cfg_q.monitored_axis;
	assign mon_oh = 4'h1 << mon;
	assign tgt_mask = target_decode(mon, cfg_q.target_axis_code);
	// Source bit picks encoder or commanded count for the monitored axis
	assign watched_pos = src_q[SRC_SEL_LSB + 32'(mon)] ?
		axis_in[mon].encoder_position_counter :
		axis_in[mon].commanded_position_counter;

	// Reconfiguring invalidates the remembered levels of the old selection
	assign restart = boot_q || (wr_commit && (wb_adr_i == OFS_CFG || wb_adr_i == OFS_SRC));

	asu_factor_detect u_detect (
		.clk(core_clk),
		.rst_n(rst_n),
		.restart(restart),
		.position(watched_pos),
		.cmp_hi(cmp_hi),
		.cmp_lo(cmp_lo),
		.driving(axis_in[mon].driving),
		.gin3(gin3_q[mon]),
		.factors(factors)
	);

	assign fired = factors & cfg_q.trigger_factor_mask;
	assign fire = |fired;

	// Host-visible configuration, capture and status
	always_comb begin
		cfg_d = cfg_q;
		src_d = src_q;
		capture_d = capture_q;
		last_d = last_q;
		if (wr_commit && wb_adr_i == OFS_CFG) begin
			cfg_d = lane_merge(cfg_q, wb_dat_i, wb_sel_i, CFG_WMASK);
		end
		if (wr_commit && wb_adr_i == OFS_SRC) begin
			src_d = lane_merge(src_q, wb_dat_i, wb_sel_i, SRC_WMASK);
		end
		if (wr_commit && in_bank && bank_idx < IDX_PRESET && wb_sel_i != 4'h0) begin
			src_d[SRC_LIMIT_LSB + 32'(bank_idx[1:0])] = 1'b0;
		end
		if (fire) begin
			last_d = fired;
			unique case (cfg_q.capture_action_code)
				CAP_COMMANDED: capture_d = axis_in[mon].commanded_position_counter;
				CAP_ENCODER: capture_d = axis_in[mon].encoder_position_counter;
				default: capture_d = capture_q;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= CFG_RST;
			src_q <= SRC_RST;
			capture_q <= WORD_RST;
			last_q <= 8'h00;
		end else begin
			cfg_q <= cfg_d;
			src_q <= src_d;
			capture_q <= capture_d;
			last_q <= last_d;
		end
	end

	assign soft_limit_en = src_q[SRC_LIMIT_LSB +: 4];

	// Per-axis action pulses, one cycle, on the clock after the factor
	generate
		for (genvar a = 0; a < AXES; a++) begin : g_act
			logic tgt;
			logic idle;
			logic ld;
			assign tgt = tgt_mask[a];
			// Starts are dropped for an axis that is already moving
			assign idle = tgt && !axis_in[a].driving;
			// Loads reach the monitored axis as well as the targets
			assign ld = tgt || mon_oh[a];
			always_comb begin
				act_d[a] = '0;
				if (fire) begin
					act_d[a].fixed_pulse_forward =
						idle && cfg_q.drive_action_code == DRV_FIXED_FWD;
					act_d[a].fixed_pulse_reverse =
						idle && cfg_q.drive_action_code == DRV_FIXED_REV;
					act_d[a].continuous_pulse_forward =
						idle && cfg_q.drive_action_code == DRV_CONT_FWD;
					act_d[a].continuous_pulse_reverse =
						idle && cfg_q.drive_action_code == DRV_CONT_REV;
					act_d[a].decelerating_halt =
						tgt && cfg_q.drive_action_code == DRV_DECEL_HALT;
					act_d[a].instant_halt =
						tgt && cfg_q.drive_action_code == DRV_INSTANT_HALT;
					act_d[a].load_commanded_position =
						ld && cfg_q.load_action_code == LOAD_COMMANDED;
					act_d[a].load_encoder_position =
						ld && cfg_q.load_action_code == LOAD_ENCODER;
					act_d[a].load_pulse_offset =
						ld && cfg_q.load_action_code == LOAD_OFFSET;
					act_d[a].load_drive_speed =
						ld && cfg_q.load_action_code == LOAD_SPEED;
				end
			end
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					axis_act[a] <= '0;
				end else begin
					axis_act[a] <= act_d[a];
				end
			end
		end
	endgenerate
endmodule

// ==== common/asu_pkg.sv ====
// How it works
// - One of the four axes is chosen as the monitored axis, watched in hardware.
// - Target code bits pick the next, second and third axes after the monitored one.
// - Trigger mask bits combine freely; any enabled factor fires; zero mask disables.
// - Bit 0 fires when position reaches upper compare; bit 1 when it drops below.
// - Bit 2 fires when position drops below lower compare; bit 3 when it reaches it.
// - Bit 4 fires when the monitored axis starts driving; bit 5 when it stops.
// - Bit 6 fires on a rising third general input; bit 7 on a falling one.
// - Drive code 1 starts a forward fixed-length move using the preset offset.
// - Drive code 2 starts a reverse fixed-length move using the preset offset.
// - Drive code 3 starts forward continuous output; code 4 reverse continuous output.
// - Drive starts are dropped for any target axis already moving at the trigger.
// - Code 5 halts targets with deceleration, code 6 halts at once, code 0 nothing.
// - Capture code 1 copies commanded position, code 2 encoder position, 0 nothing.
// - The captured value stays readable by the host after the trigger.
// - Load code 1 overwrites commanded position, code 2 encoder position, from preset.
// - Load code 3 makes preset the fixed-move offset; code 4 makes it the speed.
// - Per-axis source bit: 0 compares commanded position, 1 compares encoder position.
// - Writing either compare word of an axis turns off that axis's soft limit.
// - Each axis holds a host-written preset used by position, offset or speed loads.
// - The capture register is a signed 32-bit word readable by the host.
package asu_pkg;

	localparam int AXES = 4;
	localparam int BANK_WORDS = 12;

	// Byte offsets on the register bus
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_SRC = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_CAPT = 8'h0c;
	localparam logic [7:0] OFS_CMP_HI = 8'h10;
	localparam logic [7:0] OFS_CMP_LO = 8'h20;
	localparam logic [7:0] OFS_PRESET = 8'h30;
	localparam logic [7:0] OFS_END = 8'h40;

	// Bank word index bases
	localparam logic [3:0] IDX_CMP_HI = 4'h0;
	localparam logic [3:0] IDX_CMP_LO = 4'h4;
	localparam logic [3:0] IDX_PRESET = 4'h8;

	// Writable bits and reset values
	localparam logic [31:0] CFG_WMASK = 32'h073773ff;
	localparam logic [31:0] CFG_RST = 32'h00000000;
	localparam logic [31:0] SRC_WMASK = 32'h00000f0f;
	localparam logic [31:0] SRC_RST = 32'h00000000;
	localparam logic [31:0] WORD_RST = 32'h00000000;
	localparam int SRC_SEL_LSB = 0;
	localparam int SRC_LIMIT_LSB = 8;
	localparam int STAT_DRV_LSB = 0;
	localparam int STAT_LAST_LSB = 8;

	// Cycles that edge detection is held off after a reconfiguration
	localparam logic [1:0] SETTLE_CYC = 2'h2;

	// Trigger factor bit positions
	localparam int F_GE_HI = 0;
	localparam int F_LT_HI = 1;
	localparam int F_LT_LO = 2;
	localparam int F_GE_LO = 3;
	localparam int F_DRV_BEGIN = 4;
	localparam int F_DRV_END = 5;
	localparam int F_GIN3_RISE = 6;
	localparam int F_GIN3_FALL = 7;

	typedef enum logic [2:0] {
		DRV_NONE = 3'h0,
		DRV_FIXED_FWD = 3'h1,
		DRV_FIXED_REV = 3'h2,
		DRV_CONT_FWD = 3'h3,
		DRV_CONT_REV = 3'h4,
		DRV_DECEL_HALT = 3'h5,
		DRV_INSTANT_HALT = 3'h6
	} asu_drv_t;

	typedef enum logic [1:0] {
		CAP_NONE = 2'h0,
		CAP_COMMANDED = 2'h1,
		CAP_ENCODER = 2'h2
	} asu_cap_t;

	typedef enum logic [2:0] {
		LOAD_NONE = 3'h0,
		LOAD_COMMANDED = 3'h1,
		LOAD_ENCODER = 3'h2,
		LOAD_OFFSET = 3'h3,
		LOAD_SPEED = 3'h4
	} asu_load_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_PEND = 2'b01,
		BUS_ACK = 2'b10
	} asu_bus_st_t;

	// Configuration word layout, low bits last
	typedef struct packed {
		logic [4:0] rsv4;
		logic [2:0] load_action_code;
		logic [1:0] rsv3;
		logic [1:0] capture_action_code;
		logic rsv2;
		logic [2:0] drive_action_code;
		logic rsv1;
		logic [2:0] target_axis_code;
		logic [1:0] rsv0;
		logic [1:0] monitored_axis;
		logic [7:0] trigger_factor_mask;
	} asu_cfg_t;

	typedef struct packed {
		logic [31:0] commanded_position_counter;
		logic [31:0] encoder_position_counter;
		logic driving;
	} asu_axis_in_t;

	typedef struct packed {
		logic fixed_pulse_forward;
		logic fixed_pulse_reverse;
		logic continuous_pulse_forward;
		logic continuous_pulse_reverse;
		logic decelerating_halt;
		logic instant_halt;
		logic load_commanded_position;
		logic load_encoder_position;
		logic load_pulse_offset;
		logic load_drive_speed;
	} asu_axis_act_t;

endpackage

// ==== verilog/asu_word_bank.sv ====
`timescale 1ns/1ps
module asu_word_bank #(
	parameter int W = 32,
	parameter int WORDS = 12,
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_idx,
	input wire logic [W/8-1:0] wr_sel,
	input wire logic [W-1:0] wr_data,
	input wire logic [AW-1:0] rd_idx,
	output logic [W-1:0] rd_data,
	input wire logic [AW-1:0] hi_idx,
	input wire logic [AW-1:0] lo_idx,
	output logic [W-1:0] hi_data,
	output logic [W-1:0] lo_data,
	output logic [WORDS-1:0][W-1:0] words
);
	import asu_pkg::*;

	initial begin
		if (W % 8 != 0 || WORDS < 2 || (1 << AW) < WORDS) begin
			$error("asu_word_bank: unsupported geometry");
		end
	end

	logic [WORDS-1:0][W-1:0] mem_d;
	logic [W-1:0] rd_d;
	logic [W-1:0] hi_d;
	logic [W-1:0] lo_d;

	// Byte-lane write and three registered read ports
	always_comb begin
		mem_d = words;
		if (wr_en && 32'(wr_idx) < WORDS) begin
			for (int b = 0; b < W / 8; b++) begin
				if (wr_sel[b]) begin
					mem_d[wr_idx][b*8 +: 8] = wr_data[b*8 +: 8];
				end
			end
		end
		// Out-of-range indices read zero rather than wrap
		rd_d = (32'(rd_idx) < WORDS) ? words[rd_idx] : '0;
		hi_d = (32'(hi_idx) < WORDS) ? words[hi_idx] : '0;
		lo_d = (32'(lo_idx) < WORDS) ? words[lo_idx] : '0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			words <= '0;
			rd_data <= '0;
			hi_data <= '0;
			lo_data <= '0;
		end else begin
			words <= mem_d;
			rd_data <= rd_d;
			hi_data <= hi_d;
			lo_data <= lo_d;
		end
	end
endmodule

// ==== verilog/asu_factor_detect.sv ====
`timescale 1ns/1ps
module asu_factor_detect (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic restart,
	input wire logic [31:0] position,
	input wire logic [31:0] cmp_hi,
	input wire logic [31:0] cmp_lo,
	input wire logic driving,
	input wire logic gin3,
	output logic [7:0] factors
);
	import asu_pkg::*;

	logic ge_hi;
	logic ge_lo;
	logic [3:0] prev_d;
	logic [3:0] prev_q;
	logic [1:0] settle_d;
	logic [1:0] settle_q;
	logic [7:0] fac_d;

	// Signed comparisons against both compare words
	assign ge_hi = $signed(position) >= $signed(cmp_hi);
	assign ge_lo = $signed(position) >= $signed(cmp_lo);

	// Edges of the level conditions become single-cycle factors
	always_comb begin
		prev_d = {gin3, driving, ge_lo, ge_hi};
		settle_d = settle_q;
		fac_d = '0;
		if (restart) begin
			settle_d = SETTLE_CYC;
		end else if (settle_q != 2'h0) begin
			// Previous levels are stale after a reconfiguration
			settle_d = settle_q - 2'h1;
		end else begin
			fac_d[F_GE_HI] = ge_hi && !prev_q[0];
			fac_d[F_LT_HI] = !ge_hi && prev_q[0];
			fac_d[F_LT_LO] = !ge_lo && prev_q[1];
			fac_d[F_GE_LO] = ge_lo && !prev_q[1];
			fac_d[F_DRV_BEGIN] = driving && !prev_q[2];
			fac_d[F_DRV_END] = !driving && prev_q[2];
			fac_d[F_GIN3_RISE] = gin3 && !prev_q[3];
			fac_d[F_GIN3_FALL] = !gin3 && prev_q[3];
		end
	end

	// Settle after reset too, so power-up levels fire nothing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= 4'h0;
			settle_q <= SETTLE_CYC;
			factors <= 8'h00;
		end else begin
			prev_q <= prev_d;
			settle_q <= settle_d;
			factors <= fac_d;
		end
	end
endmodule

// ==== testbench/asu_sync_action_props.sv ====
`timescale 1ns/1ps
module asu_sync_action_chk
	import asu_pkg::*;
#(
	parameter int AXES = 4
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire asu_pkg::asu_axis_in_t [AXES-1:0] axis_in,
	input wire logic [AXES-1:0] gin3_pin,
	input wire asu_pkg::asu_axis_act_t [AXES-1:0] axis_act,
	input wire logic [AXES-1:0][31:0] preset_value,
	input wire logic [AXES-1:0] soft_limit_en
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// Bus answer: fixed two-cycle latency, one-cycle acknowledge
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack stood longer than one cycle");
	a_ack_latency: assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##2 wb_ack_o)
		else $error("ack not two cycles after request");
	a_reset_quiet: assert property ($rose(rstn) |-> ##1
		(axis_act == '0 && soft_limit_en == '0))
		else $error("outputs active just after reset");
	a_preset_write: assert property (wb_ack_o && wb_we_i && wb_sel_i == 4'hf &&
		wb_adr_i[7:4] == 4'h3 |-> preset_value[wb_adr_i[3:2]] == wb_dat_i)
		else $error("preset word not written");
	a_limit_clear: assert property (wb_ack_o && wb_we_i && wb_sel_i != 4'h0 &&
		(wb_adr_i[7:4] == 4'h1 || wb_adr_i[7:4] == 4'h2) |-> !soft_limit_en[wb_adr_i[3:2]])
		else $error("soft limit kept after compare write");

	// Per-axis action pulses: starts only on idle axes, one code at a time
	for (genvar a = 0; a < AXES; a++) begin : g_ax
		a_start_idle: assert property (|axis_act[a][9:6] |-> !$past(axis_in[a].driving))
			else $error("start issued to a moving axis");
		a_drive_excl: assert property ($onehot0(axis_act[a][9:4]))
			else $error("two drive actions at once");
		a_load_excl: assert property ($onehot0(axis_act[a][3:0]))
			else $error("two load actions at once");
	end
endmodule

bind asu_sync_action asu_sync_action_chk #(.AXES(AXES)) u_asu_sync_action_chk (
	.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .axis_in(axis_in), .gin3_pin(gin3_pin),
	.axis_act(axis_act), .preset_value(preset_value), .soft_limit_en(soft_limit_en));

// ==== testbench/asu_axis_model.sv ====
`timescale 1ns/1ps
module asu_axis_model
	import asu_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire asu_pkg::asu_axis_act_t [asu_pkg::AXES-1:0] axis_act,
	input wire logic [asu_pkg::AXES-1:0][31:0] preset_value,
	input wire logic [asu_pkg::AXES-1:0] ext_drive,
	output asu_pkg::asu_axis_in_t [asu_pkg::AXES-1:0] axis_in
);
	logic [AXES-1:0][31:0] cmd_q, enc_q;
	logic [AXES-1:0] run_q;
	logic [AXES-1:0][1:0] len_q;

	// Drives: a fixed move runs three cycles, a continuous one until halted
	always_ff @(posedge core_clk or negedge rstn) begin
		for (int a = 0; a < AXES; a++) begin
			if (!rstn) begin
				cmd_q[a] <= 32'(a + 1) << 8;
				enc_q[a] <= (32'(a + 1) << 8) + 32'h1000;
				run_q[a] <= 1'b0;
				len_q[a] <= 2'h0;
			end else begin
				// Halts win, so a stray start cannot outlive them
				if (axis_act[a].decelerating_halt || axis_act[a].instant_halt) begin
					run_q[a] <= 1'b0;
					len_q[a] <= 2'h0;
				end else if (axis_act[a].continuous_pulse_forward ||
					axis_act[a].continuous_pulse_reverse) begin
					run_q[a] <= 1'b1;
				end else if (axis_act[a].fixed_pulse_forward || axis_act[a].fixed_pulse_reverse) begin
					len_q[a] <= 2'h3;
				end else if (len_q[a] != 2'h0) begin
					len_q[a] <= len_q[a] - 2'h1;
				end
				if (axis_act[a].load_commanded_position) cmd_q[a] <= preset_value[a];
				if (axis_act[a].load_encoder_position) enc_q[a] <= preset_value[a];
			end
		end
	end

	// Counters stand still; a move only shows as the driving flag
	always_comb begin
		for (int a = 0; a < AXES; a++) begin
			axis_in[a].commanded_position_counter = cmd_q[a];
			axis_in[a].encoder_position_counter = enc_q[a];
			axis_in[a].driving = run_q[a] | (len_q[a] != 2'h0) | ext_drive[a];
		end
	end
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import asu_pkg::*;
	logic core_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, clr;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	asu_axis_in_t [AXES-1:0] axis_in;
	asu_axis_act_t [AXES-1:0] axis_act;
	logic [AXES-1:0][31:0] preset_value;
	logic [AXES-1:0] gin3_pin, soft_limit_en, ext_drive;
	logic [AXES-1:0][9:0] seen;
	int fail_count, num_checks;
	asu_cfg_t cfg;

	asu_sync_action #(.AXES(AXES)) u_asu_sync_action (.core_clk(core_clk), .rstn(rstn),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.axis_in(axis_in), .gin3_pin(gin3_pin), .axis_act(axis_act),
		.preset_value(preset_value), .soft_limit_en(soft_limit_en));
	asu_axis_model u_asu_axis_model (.core_clk(core_clk), .rstn(rstn), .axis_act(axis_act),
		.preset_value(preset_value), .ext_drive(ext_drive), .axis_in(axis_in));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Sticky record so a one-cycle pulse is never missed
	always @(posedge core_clk) seen <= clr ? '0 : seen | axis_act;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Classic single cycle; request held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int i;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hf;
		wb_dat_i <= dat;
		for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge core_clk);
		if (i == 20) begin
			fail_count++;
			$display("Error at %0t: no bus answer", $time);
			wrap_up();
		end else begin
			rd = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
		end
	endtask

	// Toggle general input three; detection is held off just after a config write
	task automatic fire(input int m);
		idle(4);
		gin3_pin[m] <= ~gin3_pin[m];
		idle(8);
	endtask

	task automatic t_reset;
		wb(1'b0, OFS_CFG, 32'h0);
		chk(rd, CFG_RST);
		wb(1'b0, OFS_SRC, 32'h0);
		chk(rd, SRC_RST);
		wb(1'b1, OFS_END, 32'hffffffff);
		wb(1'b0, OFS_END, 32'h0);
		chk(rd, 32'h0);
	endtask

	task automatic t_factors;
		int ord[8] = '{1, 0, 2, 3, 4, 5, 6, 7};
		int f;
		for (int k = 0; k < 8; k++) begin
			f = ord[k];
			cfg = '0;
			cfg.trigger_factor_mask = 8'h1 << f;
			wb(1'b1, OFS_CFG, cfg);
			idle(4);
			case (f)
				0: wb(1'b1, OFS_CMP_HI, 32'h100);
				1: wb(1'b1, OFS_CMP_HI, 32'h101);
				2: wb(1'b1, OFS_CMP_LO, 32'h101);
				3: wb(1'b1, OFS_CMP_LO, 32'h100);
				4, 5: ext_drive[0] <= (f == 4);
				default: gin3_pin[0] <= (f == 6);
			endcase
			idle(8);
			wb(1'b0, OFS_STAT, 32'h0);
			chk(rd[15:8], 8'h1 << f);
		end
		// Two factors enabled; the disabled falling edge must not fire
		cfg.trigger_factor_mask = 8'h41;
		wb(1'b1, OFS_CFG, cfg);
		fire(0);
		wb(1'b0, OFS_STAT, 32'h0);
		chk(rd[15:8], 8'h40);
		gin3_pin[0] <= 1'b0;
		idle(8);
		wb(1'b0, OFS_STAT, 32'h0);
		chk(rd[15:8], 8'h40);
		// Encoder source: a compare word between the two counts tells them apart
		cfg.trigger_factor_mask = 8'h02;
		wb(1'b1, OFS_CFG, cfg);
		wb(1'b1, OFS_SRC, 32'h00000001);
		wb(1'b1, OFS_CMP_HI, 32'h1000);
		idle(8);
		wb(1'b0, OFS_STAT, 32'h0);
		chk(rd[15:8], 8'h40);
		wb(1'b1, OFS_CMP_HI, 32'h1101);
		idle(8);
		wb(1'b0, OFS_STAT, 32'h0);
		chk(rd[15:8], 8'h02);
	endtask

	task automatic t_actions;
		logic [15:0] tab[6] = '{16'h0113, 16'h1223, 16'h2434, 16'h3740, 16'h0750, 16'h1560};
		logic [15:0] e;
		logic [3:0] busy, tgt;
		logic [9:0] exp;
		int m;
		for (int k = 0; k < 6; k++) begin
			e = tab[k];
			m = e[13:12];
			cfg = '0;
			cfg.trigger_factor_mask = 8'hc0;
			cfg.monitored_axis = e[13:12];
			cfg.target_axis_code = e[10:8];
			cfg.drive_action_code = e[6:4];
			cfg.load_action_code = e[2:0];
			wb(1'b1, OFS_CFG, cfg);
			clr <= 1'b1;
			idle(1);
			clr <= 1'b0;
			tgt = 4'h0;
			for (int j = 0; j < 3; j++) if (e[8 + j]) tgt[(m + j + 1) % 4] = 1'b1;
			for (int a = 0; a < 4; a++) busy[a] = axis_in[a].driving;
			fire(m);
			for (int a = 0; a < 4; a++) begin
				exp = 10'h0;
				if (tgt[a] && !(e[6:4] <= 3'h4 && busy[a])) exp = 10'h1 << (10 - e[6:4]);
				if ((tgt[a] || a == m) && e[2:0] != 3'h0) exp |= 10'h1 << (4 - e[2:0]);
				chk(seen[a], exp);
			end
		end
	endtask

	task automatic t_capture;
		logic [31:0] old;
		wb(1'b1, OFS_PRESET + 8'h4, 32'h12345678);
		wb(1'b1, OFS_PRESET + 8'h8, 32'hfedc0001);
		for (int c = 1; c < 3; c++) begin
			cfg = '0;
			cfg.trigger_factor_mask = 8'hc0;
			cfg.monitored_axis = 2'h1;
			cfg.target_axis_code = 3'h1;
			cfg.capture_action_code = 2'(c);
			cfg.load_action_code = 3'(c);
			wb(1'b1, OFS_CFG, cfg);
			old = c == 1 ? axis_in[1].commanded_position_counter : axis_in[1].encoder_position_counter;
			fire(1);
			wb(1'b0, OFS_CAPT, 32'h0);
			chk(rd, old);
			chk(c == 1 ? axis_in[1].commanded_position_counter : axis_in[1].encoder_position_counter,
				32'h12345678);
			chk(c == 1 ? axis_in[2].commanded_position_counter : axis_in[2].encoder_position_counter,
				32'hfedc0001);
		end
		// Capture off and a stray write: the held value must survive both
		cfg.capture_action_code = 2'h0;
		wb(1'b1, OFS_CFG, cfg);
		fire(1);
		wb(1'b1, OFS_CAPT, 32'h0);
		wb(1'b0, OFS_CAPT, 32'h0);
		chk(rd, old);
	endtask

	task automatic t_limit;
		wb(1'b1, OFS_SRC, 32'h00000f00);
		chk(soft_limit_en, 4'hf);
		wb(1'b1, OFS_CMP_LO + 8'h8, 32'h0);
		chk(soft_limit_en, 4'hb);
	endtask

	initial begin
		rstn = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h0;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		gin3_pin = '0;
		ext_drive = '0;
		clr = 1'b0;
		fail_count = 0;
		num_checks = 0;
		idle(6);
		rstn <= 1'b1;
		idle(4);
		t_reset();
		t_factors();
		t_actions();
		t_capture();
		t_limit();
		wrap_up();
	end
endmodule
